// *** logic/loop_code_patterns.v ***
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "loop_code_map.vh"

module loop_code_patterns (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // AXI4-Lite write address
    input wire [11:0] awaddr,
    input wire awvalid,
    output reg awready,
    // AXI4-Lite write data
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    // AXI4-Lite write response
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // AXI4-Lite read address
    input wire [11:0] araddr,
    input wire arvalid,
    output reg arready,
    // AXI4-Lite read data
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // Transmit code stream
    output reg tx_code_bit,
    output reg tx_code_strobe,
    // Up-code detector setup
    output reg [15:0] up_compare,
    output reg [15:0] up_mask,
    output reg up_restart,
    // Down-code detector setup
    output reg [15:0] down_compare,
    output reg [15:0] down_mask,
    output reg down_restart,
    // Spare-code length for its detector
    output reg [15:0] spare_mask
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [7:0] tx_loop_pattern_hi;
    reg [7:0] tx_loop_pattern_lo;
    reg [7:0] rx_up_pattern_hi;
    reg [7:0] rx_up_pattern_lo;
    reg [7:0] rx_down_pattern_hi;
    reg [7:0] rx_down_pattern_lo;
    reg [7:0] spare_pattern_length_ctl;
    reg [7:0] code_length_ctl;
    reg [7:0] loop_enable;

    // Bus capture state
    reg aw_held;
    reg w_held;
    reg [11:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    // Transmit generator state
    localparam [31:0] BIT_RELOAD = `TX_BIT_DIV - 1;
    reg [7:0] bit_div;
    reg [3:0] tx_idx;

    wire tx_en;
    wire [1:0] tx_len_sel;
    wire [2:0] up_len_sel;
    wire [2:0] down_len_sel;
    wire [2:0] spare_len_sel;
    wire [15:0] tx_code;
    wire [3:0] tx_last;
    wire bit_tick;
    wire [15:0] next_up_mask;
    wire [15:0] next_up_compare;
    wire [15:0] next_down_mask;
    wire [15:0] next_down_compare;
    wire [15:0] next_spare_mask;
    wire [15:0] unused_spare_masked;
    wire do_write;
    wire [7:0] wr_idx;
    wire [7:0] rd_idx;
    wire wr_hit;
    reg [7:0] rd_byte;
    reg rd_hit;
    reg [3:0] tx_last_sel;
    reg tx_code_next;

    // ----------------------------------------
    // Field decode
    // ----------------------------------------
    assign tx_en = loop_enable[`TX_ENABLE_BIT];
    assign tx_len_sel = code_length_ctl[`TX_LEN_HI:`TX_LEN_LO];
    assign up_len_sel = code_length_ctl[`UP_LEN_HI:`UP_LEN_LO];
    assign down_len_sel = code_length_ctl[`DOWN_LEN_HI:`DOWN_LEN_LO];
    // Upper spare bits are stored for read-back but never steer logic
    assign spare_len_sel = spare_pattern_length_ctl[`SPARE_LEN_HI:`SPARE_LEN_LO];
    assign tx_code = {tx_loop_pattern_hi, tx_loop_pattern_lo};
    assign tx_last = tx_last_sel;

    // ----------------------------------------
    // Bus address decode
    // ----------------------------------------
    assign do_write = aw_held && w_held && !bvalid;
    assign wr_idx = aw_addr_q[9:2];
    assign rd_idx = araddr[9:2];
    // Only aligned words below the index space decode
    assign wr_hit = (aw_addr_q[1:0] == 2'h0) && (aw_addr_q[11:10] == 2'h0) &&
        ((wr_idx >= `IDX_TX_LOOP_PATTERN_HI && wr_idx <= `IDX_SPARE_PATTERN_LENGTH_CTL) ||
        wr_idx == `IDX_CODE_LENGTH_CTL || wr_idx == `IDX_LOOP_ENABLE ||
        wr_idx == `IDX_LOOP_STATUS);

    // ----------------------------------------
    // Receive masks by length code
    // ----------------------------------------
    pattern_mask up_lane (
        .len_sel(up_len_sel),
        .pat_hi(rx_up_pattern_hi),
        .pat_lo(rx_up_pattern_lo),
        .mask(next_up_mask),
        .masked(next_up_compare)
    );

    pattern_mask down_lane (
        .len_sel(down_len_sel),
        .pat_hi(rx_down_pattern_hi),
        .pat_lo(rx_down_pattern_lo),
        .mask(next_down_mask),
        .masked(next_down_compare)
    );

    // Spare patterns live elsewhere; only the mask is produced here
    pattern_mask spare_lane (
        .len_sel(spare_len_sel),
        .pat_hi(8'h00),
        .pat_lo(8'h00),
        .mask(next_spare_mask),
        .masked(unused_spare_masked)
    );

    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    // Address and data are taken in either order, answered once both are in
    always @(posedge core_clk) begin
        if (!rstn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                awready <= 1'b0;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                wready <= 1'b0;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (do_write) begin
                bvalid <= 1'b1;
                bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    // Lane 0 strobe gates every byte-wide register; status is read-only
    always @(posedge core_clk) begin
        if (!rstn) begin
            tx_loop_pattern_hi <= `REG_RESET;
            tx_loop_pattern_lo <= `REG_RESET;
            rx_up_pattern_hi <= `REG_RESET;
            rx_up_pattern_lo <= `REG_RESET;
            rx_down_pattern_hi <= `REG_RESET;
            rx_down_pattern_lo <= `REG_RESET;
            spare_pattern_length_ctl <= `REG_RESET;
            code_length_ctl <= `REG_RESET;
            loop_enable <= `REG_RESET;
        end else if (do_write && w_strb_q[0] && wr_hit) begin
            // Refused addresses must not alias onto a stored byte
            case (wr_idx)
                `IDX_TX_LOOP_PATTERN_HI: begin
                    tx_loop_pattern_hi <= w_data_q[7:0];
                end
                `IDX_TX_LOOP_PATTERN_LO: begin
                    tx_loop_pattern_lo <= w_data_q[7:0];
                end
                `IDX_RX_UP_PATTERN_HI: begin
                    rx_up_pattern_hi <= w_data_q[7:0];
                end
                `IDX_RX_UP_PATTERN_LO: begin
                    rx_up_pattern_lo <= w_data_q[7:0];
                end
                `IDX_RX_DOWN_PATTERN_HI: begin
                    rx_down_pattern_hi <= w_data_q[7:0];
                end
                `IDX_RX_DOWN_PATTERN_LO: begin
                    rx_down_pattern_lo <= w_data_q[7:0];
                end
                `IDX_SPARE_PATTERN_LENGTH_CTL: begin
                    spare_pattern_length_ctl <= w_data_q[7:0];
                end
                `IDX_CODE_LENGTH_CTL: begin
                    code_length_ctl <= w_data_q[7:0];
                end
                `IDX_LOOP_ENABLE: begin
                    loop_enable <= w_data_q[7:0];
                end
                default: begin
                    loop_enable <= loop_enable;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Detector restart pulses
    // ----------------------------------------
    // One cycle, raised with the stored byte and the write answer
    always @(posedge core_clk) begin
        if (!rstn) begin
            up_restart <= 1'b0;
            down_restart <= 1'b0;
        end else begin
            up_restart <= do_write && w_strb_q[0] && wr_hit && wr_idx == `IDX_RX_UP_PATTERN_HI;
            down_restart <= do_write && w_strb_q[0] && wr_hit && wr_idx == `IDX_RX_DOWN_PATTERN_HI;
        end
    end

    // ----------------------------------------
    // Registered detector setup
    // ----------------------------------------
    // Bit 15 of each compare word is the first pattern bit
    always @(posedge core_clk) begin
        if (!rstn) begin
            up_compare <= 16'h0000;
            up_mask <= 16'h0000;
            down_compare <= 16'h0000;
            down_mask <= 16'h0000;
            spare_mask <= 16'h0000;
        end else begin
            up_compare <= next_up_compare;
            up_mask <= next_up_mask;
            down_compare <= next_down_compare;
            down_mask <= next_down_mask;
            spare_mask <= next_spare_mask;
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    always @* begin
        rd_hit = (araddr[1:0] == 2'h0) && (araddr[11:10] == 2'h0);
        case (rd_idx)
            `IDX_TX_LOOP_PATTERN_HI: rd_byte = tx_loop_pattern_hi;
            `IDX_TX_LOOP_PATTERN_LO: rd_byte = tx_loop_pattern_lo;
            `IDX_RX_UP_PATTERN_HI: rd_byte = rx_up_pattern_hi;
            `IDX_RX_UP_PATTERN_LO: rd_byte = rx_up_pattern_lo;
            `IDX_RX_DOWN_PATTERN_HI: rd_byte = rx_down_pattern_hi;
            `IDX_RX_DOWN_PATTERN_LO: rd_byte = rx_down_pattern_lo;
            `IDX_SPARE_PATTERN_LENGTH_CTL: rd_byte = spare_pattern_length_ctl;
            `IDX_CODE_LENGTH_CTL: rd_byte = code_length_ctl;
            `IDX_LOOP_ENABLE: rd_byte = loop_enable;
            `IDX_LOOP_STATUS: rd_byte = {2'h0, tx_code_bit, tx_en, tx_idx};
            default: begin
                rd_byte = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Data is sampled at the address handshake and held until taken
    always @(posedge core_clk) begin
        if (!rstn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h000000, rd_byte};
            rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ----------------------------------------
    // Transmit bit-rate divider
    // ----------------------------------------
    assign bit_tick = (bit_div == 8'h00);

    always @(posedge core_clk) begin
        if (!rstn || !tx_en) begin
            bit_div <= 8'h00;
        end else if (bit_tick) begin
            bit_div <= BIT_RELOAD[7:0];
        end else begin
            bit_div <= bit_div - 8'h01;
        end
    end

    // ----------------------------------------
    // Transmit code generator
    // ----------------------------------------
    // Last index per length; short lengths never reach the low byte
    always @* begin
        case (tx_len_sel)
            `TX_SEL_5: tx_last_sel = `TX_LAST_5;
            `TX_SEL_6: tx_last_sel = `TX_LAST_6;
            `TX_SEL_7: tx_last_sel = `TX_LAST_7;
            default: tx_last_sel = `TX_LAST_16;
        endcase
        tx_code_next = tx_code[4'hf - tx_idx];
    end

    // Index restarts at zero so every repetition opens with the top bit
    always @(posedge core_clk) begin
        if (!rstn || !tx_en) begin
            tx_idx <= 4'h0;
            tx_code_bit <= 1'b0;
            tx_code_strobe <= 1'b0;
        end else begin
            tx_code_strobe <= bit_tick;
            if (bit_tick) begin
                tx_code_bit <= tx_code_next;
                // A length shortened mid-pattern wraps at once
                tx_idx <= (tx_idx >= tx_last) ? 4'h0 : tx_idx + 4'h1;
            end
        end
    end

endmodule

`default_nettype wire

// *** logic/pattern_mask.v ***
`timescale 1ns/100ps
`default_nettype none
`include "loop_code_map.vh"

// Masks a 16-bit receive pattern by its 3-bit length code
module pattern_mask (
    // Length code and pattern
    input wire [2:0] len_sel,
    input wire [7:0] pat_hi,
    input wire [7:0] pat_lo,
    // Compare mask and masked pattern
    output wire [15:0] mask,
    output wire [15:0] masked
);

    // Code L-1 keeps bits 7 down to 8-L; full code keeps both bytes
    wire [7:0] hi_mask;
    wire [7:0] lo_mask;
    wire [3:0] shift;

    assign shift = {1'b0, len_sel} + 4'h1;
    assign hi_mask = ~(8'hff >> shift);
    assign lo_mask = (len_sel == `LEN_SEL_FULL) ? 8'hff : 8'h00;
    assign mask = {hi_mask, lo_mask};
    assign masked = {pat_hi, pat_lo} & mask;

endmodule

`default_nettype wire

// *** pkg/loop_code_map.vh ***
`ifndef LOOP_CODE_MAP_VH
`define LOOP_CODE_MAP_VH

// ----------------------------------------
// Register indexes, byte address = 4 * index
// ----------------------------------------
`define IDX_TX_LOOP_PATTERN_HI 8'hb7
`define IDX_TX_LOOP_PATTERN_LO 8'hb8
`define IDX_RX_UP_PATTERN_HI 8'hb9
`define IDX_RX_UP_PATTERN_LO 8'hba
`define IDX_RX_DOWN_PATTERN_HI 8'hbb
`define IDX_RX_DOWN_PATTERN_LO 8'hbc
`define IDX_SPARE_PATTERN_LENGTH_CTL 8'hbd
`define IDX_CODE_LENGTH_CTL 8'hf0
`define IDX_LOOP_ENABLE 8'hf1
`define IDX_LOOP_STATUS 8'hf2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define REG_RESET 8'h00

// ----------------------------------------
// Field positions of the code length, spare length and loop enable registers
// ----------------------------------------
`define TX_LEN_HI 7
`define TX_LEN_LO 6
`define UP_LEN_HI 5
`define UP_LEN_LO 3
`define DOWN_LEN_HI 2
`define DOWN_LEN_LO 0
`define SPARE_LEN_HI 2
`define SPARE_LEN_LO 0
`define TX_ENABLE_BIT 0

// ----------------------------------------
// Transmit length codes and lengths
// ----------------------------------------
`define TX_SEL_5 2'h0
`define TX_SEL_6 2'h1
`define TX_SEL_7 2'h2
`define TX_SEL_16 2'h3
`define TX_LAST_5 4'h4
`define TX_LAST_6 4'h5
`define TX_LAST_7 4'h6
`define TX_LAST_16 4'hf
`define LEN_SEL_FULL 3'h7

// ----------------------------------------
// Timing: core clock 20 MHz, line bit 1.544 Mb/s nominal; the divider of 12 gives about 1.667 Mb/s
// ----------------------------------------
`define CORE_CLK_HZ 20000000
`define LINE_BIT_HZ 1544000
`define TX_BIT_DIV (`CORE_CLK_HZ / `LINE_BIT_HZ)

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** verif/loop_code_checks_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "loop_code_map.vh"
// --------
// Port checks
// --------
module loop_code_checks (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Write bus
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    // Code outputs
    input wire logic tx_code_strobe,
    input wire logic [15:0] up_compare,
    input wire logic [15:0] up_mask,
    input wire logic up_restart,
    input wire logic [15:0] down_compare,
    input wire logic [15:0] down_mask,
    input wire logic down_restart,
    input wire logic [15:0] spare_mask
);
    localparam logic [11:0] UP_HI = {2'b00, `IDX_RX_UP_PATTERN_HI, 2'b00};
    localparam logic [11:0] DN_HI = {2'b00, `IDX_RX_DOWN_PATTERN_HI, 2'b00};
    logic [11:0] aw_q;
    logic lane0_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // Address and lane of the write in flight, for judging restarts
    always @(posedge core_clk) begin
        if (awvalid && awready) aw_q <= awaddr;
        if (wvalid && wready) lane0_q <= wstrb[0];
    end

    // A write that completed and stored a byte at one address
    sequence s_stored(logic [11:0] a);
        $rose(bvalid) && bresp == `RESP_OKAY && lane0_q && aw_q == a;
    endsequence
    // High byte a leading run of ones only; compare never outside the mask
    property p_shape(logic [15:0] m, logic [15:0] c);
        ((~m[15:8]) & ((~m[15:8]) + 8'h01)) == 8'h00 && (c & ~m) == 16'h0000;
    endproperty
    // Low byte only at the full length
    property p_lo_gate(logic [15:0] m);
        m[7:0] != 8'h00 |-> m == 16'hffff;
    endproperty

    a_up_restart_pulse:
        assert property (s_stored(UP_HI) |-> up_restart) else $error("up restart missing");
    a_down_restart_pulse:
        assert property (s_stored(DN_HI) |-> down_restart) else $error("down restart missing");
    a_up_restart_cause:
        assert property (up_restart |-> bvalid && aw_q == UP_HI) else $error("stray up restart");
    a_up_hi_shape:
        assert property (p_shape(up_mask, up_compare)) else $error("up mask shape");
    a_down_hi_shape:
        assert property (p_shape(down_mask, down_compare)) else $error("down mask shape");
    a_up_lo_gate:
        assert property (p_lo_gate(up_mask)) else $error("up low byte used");
    a_down_lo_gate:
        assert property (p_lo_gate(down_mask)) else $error("down low byte used");
    a_spare_lo_gate:
        assert property (p_lo_gate(spare_mask)) else $error("spare low byte used");
    a_strobe_spacing:
        assert property (tx_code_strobe |=> !tx_code_strobe [*8]) else $error("bit strobes too close");
    a_bresp_holds:
        assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write answer dropped");
endmodule

bind loop_code_patterns loop_code_checks i_loop_code_checks (
    .core_clk, .rstn, .awaddr, .awvalid, .awready, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .tx_code_strobe, .up_compare, .up_mask, .up_restart, .down_compare, .down_mask,
    .down_restart, .spare_mask
);
`default_nettype wire

// *** verif/test_loop_code_patterns.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "loop_code_map.vh"
module test_loop_code_patterns;
    // --------
    // Bus tasks and tests
    // --------
    logic core_clk;
    logic rstn;
    logic [11:0] awaddr;
    logic [11:0] araddr;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire tx_code_bit, tx_code_strobe, up_restart, down_restart;
    wire [15:0] up_compare, up_mask, down_compare, down_mask, spare_mask;
    logic [7:0] idx [0:9] = '{`IDX_TX_LOOP_PATTERN_HI, `IDX_TX_LOOP_PATTERN_LO, `IDX_RX_UP_PATTERN_HI,
        `IDX_RX_UP_PATTERN_LO, `IDX_RX_DOWN_PATTERN_HI, `IDX_RX_DOWN_PATTERN_LO,
        `IDX_SPARE_PATTERN_LENGTH_CTL, `IDX_CODE_LENGTH_CTL, `IDX_LOOP_ENABLE, `IDX_LOOP_STATUS};
    logic [31:0] rv;
    logic [1:0] rr;
    logic [7:0] v;
    logic [15:0] pat;
    logic bits [$];
    int gaps [$];
    int fail_count, n_checks, cyc, since, n_up, n_dn, len, u0, d0;

    loop_code_patterns i_loop_code_patterns (
        .core_clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .tx_code_bit, .tx_code_strobe, .up_compare, .up_mask, .up_restart,
        .down_compare, .down_mask, .down_restart, .spare_mask
    );

    // 20 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Restart counts, transmit bits with their spacing, hang ceiling
    always @(posedge core_clk) begin
        cyc++;
        since++;
        if (up_restart === 1'b1) n_up++;
        if (down_restart === 1'b1) n_dn++;
        if (tx_code_strobe === 1'b1) begin
            bits.push_back(tx_code_bit);
            gaps.push_back(since);
            since = 0;
        end
        if (cyc == 30000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    function automatic logic [11:0] ad(input int k);
        return {2'b00, idx[k], 2'b00};
    endfunction

    // Receive mask for a length code: leading c+1 bits, all 16 at code 7
    function automatic logic [15:0] msk(input int c);
        return (c == 7) ? 16'hffff : {8'hff << (7 - c), 8'h00};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rr = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        wstrb = 4'h0;
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        // Reset values, readback, refused and read-only places
        for (int k = 0; k < 10; k++) begin
            rd(ad(k));
            chk(rv, 32'h0);
        end
        for (int k = 0; k < 7; k++) begin
            v = (k == 6) ? 8'h05 : 8'h81 + 8'(k * 17);
            wr(ad(k), v, 4'h1);
            rd(ad(k));
            chk(rv, {24'h0, v});
        end
        wr(ad(0), 8'hff, 4'h0);
        rd(ad(0));
        chk(rv, 32'h81);
        wr(ad(9), 8'hff, 4'h1);
        chk(rr, `RESP_OKAY);
        rd(ad(9));
        chk(rv, 32'h0);
        wr(12'h004, 8'hff, 4'h1);
        chk(rr, `RESP_SLVERR);
        rd(12'h004);
        chk({rv[29:0], rr}, {30'h0, `RESP_SLVERR});
        wr(ad(2) | 12'h001, 8'hee, 4'h1);
        chk(rr, `RESP_SLVERR);
        rd(ad(2));
        chk(rv, 32'ha3);
        $display("test registers done");
        // Every length code; up and down codes run opposite ways
        wr(ad(2), 8'ha5, 4'h1);
        wr(ad(3), 8'h3c, 4'h1);
        wr(ad(4), 8'h5a, 4'h1);
        wr(ad(5), 8'hc3, 4'h1);
        for (int c = 0; c < 8; c++) begin
            wr(ad(7), {2'b00, 3'(c), 3'(7 - c)}, 4'h1);
            wr(ad(6), {5'h00, 3'(c)}, 4'h1);
            repeat (2) @(posedge core_clk);
            chk(up_mask, msk(c));
            chk(up_compare, 16'ha53c & msk(c));
            chk(down_mask, msk(7 - c));
            chk(down_compare, 16'h5ac3 & msk(7 - c));
            chk(spare_mask, msk(c));
        end
        $display("test masks done");
        // Restart comes from the first pattern bytes only
        u0 = n_up;
        d0 = n_dn;
        wr(ad(2), 8'ha5, 4'h1);
        wr(ad(3), 8'h77, 4'h1);
        repeat (3) @(posedge core_clk);
        chk(n_up - u0, 1);
        chk(n_dn - d0, 0);
        wr(ad(4), 8'h5a, 4'h1);
        wr(ad(5), 8'h66, 4'h1);
        repeat (3) @(posedge core_clk);
        chk(n_dn - d0, 1);
        chk(n_up - u0, 1);
        $display("test restarts done");
        // Two repetitions at each transmit length, low bits set to expose leaks
        pat = 16'hb596;
        wr(ad(0), pat[15:8], 4'h1);
        wr(ad(1), pat[7:0], 4'h1);
        for (int s = 0; s < 4; s++) begin
            len = (s == 3) ? 16 : 5 + s;
            wr(ad(7), {2'(s), 6'h00}, 4'h1);
            bits.delete();
            gaps.delete();
            wr(ad(8), 8'h01, 4'h1);
            while (bits.size() < 2 * len) @(posedge core_clk);
            wr(ad(8), 8'h00, 4'h1);
            for (int i = 0; i < 2 * len; i++) begin
                chk(bits[i], pat[15 - i % len]);
                if (i > 0) chk(gaps[i], `TX_BIT_DIV);
            end
        end
        $display("test transmit done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
